// ===== include/rss_pkg.sv
// Constants shared by the rotate / subtract / skip execution slice.
// Assumes an 8-bit core that decodes opcodes upstream and feeds
// operands from its own data memory port.
package rss_pkg;

    // Operation codes from the decoder; _TO_WREG forms spare memory
    localparam logic [4:0] OP_NOP                         = 5'h00;
    localparam logic [4:0] OP_ROTATE_LEFT_THRU_CARRY      = 5'h01;
    localparam logic [4:0] OP_ROTATE_LEFT_CARRY_TO_WREG   = 5'h02;
    localparam logic [4:0] OP_ROTATE_RIGHT_PLAIN          = 5'h03;
    localparam logic [4:0] OP_ROTATE_RIGHT_TO_WREG        = 5'h04;
    localparam logic [4:0] OP_ROTATE_RIGHT_THRU_CARRY     = 5'h05;
    localparam logic [4:0] OP_ROTATE_RIGHT_CARRY_TO_WREG  = 5'h06;
    localparam logic [4:0] OP_SUBTRACT_WITH_BORROW        = 5'h07;
    localparam logic [4:0] OP_SUBTRACT_WITH_BORROW_IMM    = 5'h08;
    localparam logic [4:0] OP_SUBTRACT_WITH_BORROW_TO_MEM = 5'h09;
    localparam logic [4:0] OP_SUB_M                       = 5'h0A;
    localparam logic [4:0] OP_SUB_X                       = 5'h0B;
    localparam logic [4:0] OP_MINUS_TO_MEM                = 5'h0C;
    localparam logic [4:0] OP_DEC_SKZ                     = 5'h0D;
    localparam logic [4:0] OP_DEC_SKZ_W                   = 5'h0E;
    localparam logic [4:0] OP_INC_SKZ                     = 5'h0F;
    localparam logic [4:0] OP_INC_SKZ_W                   = 5'h10;
    localparam logic [4:0] OP_FILL                        = 5'h11;
    localparam logic [4:0] OP_BIT_SET                     = 5'h12;
    localparam logic [4:0] OP_SKNZ                        = 5'h13;
    localparam logic [4:0] OP_SKNZ_BIT                    = 5'h14;
    localparam logic [4:0] OP_NIB_X                       = 5'h15;
    localparam logic [4:0] OP_NIB_X_W                     = 5'h16;
    localparam logic [4:0] OP_SKZ                         = 5'h17;

    // Status flag bit positions
    localparam int FLG_C              = 0;
    localparam int FLG_HALF_CARRY     = 1;
    localparam int FLG_Z              = 2;
    localparam int FLG_ARITH_WRAP     = 3;
    localparam int FLG_SIGNED_COMPARE = 4;
    localparam int FLG_CHAINED_ZERO   = 5;
    localparam int FLG_W              = 6;

    // Register word indices (byte address = 4 * index)
    localparam logic [1:0] REG_WREG  = 2'h0;
    localparam logic [1:0] REG_FLAGS = 2'h1;
    localparam logic [1:0] REG_SKIPS = 2'h2;

    // Reset values and the all-ones fill constant
    localparam logic [7:0] WREG_RST  = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_DUMMY = 2'b10
    } seq_e;

endpackage

// ===== hdl/rss_exec.sv
// Execution slice for rotate, subtract, skip, set and nibble swap ops.
// Assumes the decoder holds one operation per cycle on ex_*_i and stops
// issuing while ex_busy_o is high; the memory operand is already read.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1 - Rotate memory left through carry, write back
// RL2 - Left carry rotate into working register only
// RL3 - Plain right rotate memory, flags untouched
// RL4 - Plain right rotate into working register
// RL5 - Rotate memory right through carry, write back
// RL6 - Right carry rotate into working register only
// RL7 - Subtract with borrow into working register
// RL8 - Subtract carry is no-borrow indicator
// RL9 - Immediate subtract with borrow uses constant
// RL10 - Subtract with borrow writes memory byte
// RL11 - Plain subtract into working register
// RL12 - Plain subtract writes memory byte
// RL13 - Decrement memory, skip when zero
// RL14 - Decrement into working register, skip zero
// RL15 - Increment memory, skip when zero
// RL16 - Increment into working register, skip zero
// RL17 - Taken skip inserts one dummy cycle
// RL18 - Fill memory byte with all ones
// RL19 - Set only the selected bit
// RL20 - Skip when byte or bit nonzero
// RL21 - Swap memory nibbles in place
// RL22 - Swapped byte into working register
// RL23 - Skip when memory byte is zero
// RL24 - Untaken skip completes in one cycle
module rss_exec
    import rss_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Operation from decoder
    input  wire logic        ex_valid_i,
    input  wire logic [4:0]  ex_op_i,
    input  wire logic [7:0]  ex_mem_i,
    input  wire logic [7:0]  ex_imm_i,
    input  wire logic [2:0]  ex_bit_i,
    // Results
    output logic             ex_busy_o,
    output logic             skip_o,
    output logic             mem_we_o,
    output logic [7:0]       mem_wdata_o,
    output logic [7:0]       wreg_o,
    output logic [5:0]       flags_o,
    // Avalon-MM slave
    input  wire logic [1:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o
);

    // Subtract core: returns {wrap, half carry, carry, diff}
    function automatic logic [10:0] sub8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       brw);
        logic [8:0] d9;
        logic [4:0] d5;
        d9 = {1'b0, a} - {1'b0, b} - {8'h00, brw};
        d5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, brw};
        sub8 = {(a[7] ^ b[7]) & (a[7] ^ d9[7]), ~d5[4], ~d9[8], d9[7:0]};
    endfunction

    logic [7:0]  wreg_r, wreg_nxt;
    logic [5:0]  flags_r, flags_nxt;
    logic        mem_we_r, mem_we_nxt;
    logic [7:0]  mem_wdata_r, mem_wdata_nxt;
    logic        skip_r, busy_r;
    logic [7:0]  skips_r;
    logic [31:0] rdata_r;
    logic        wait_r;
    seq_e        state_r, state_nxt;

    // Operation accept and operand decode
    wire        take    = ex_valid_i && (state_r == ST_RUN);
    wire        c_old   = flags_r[FLG_C];
    wire [7:0]  m       = ex_mem_i;
    wire [7:0]  bitmask = 8'h01 << ex_bit_i;
    wire [7:0]  rot_lc  = {m[6:0], c_old};                        // RL1 RL2
    wire [7:0]  rot_r   = {m[0], m[7:1]};                         // RL3 RL4
    wire [7:0]  rot_rc  = {c_old, m[7:1]};                        // RL5 RL6
    wire [7:0]  nib_x   = {m[3:0], m[7:4]};                       // RL21 RL22
    wire [7:0]  dec_v   = m - 8'h01;                              // RL13 RL14
    wire [7:0]  inc_v   = m + 8'h01;                              // RL15 RL16

    // Subtrahend: immediate for the constant forms, else memory
    wire        op_imm  = (ex_op_i == OP_SUBTRACT_WITH_BORROW_IMM)
                       || (ex_op_i == OP_SUB_X);
    wire        op_brw  = (ex_op_i == OP_SUBTRACT_WITH_BORROW)
                       || (ex_op_i == OP_SUBTRACT_WITH_BORROW_IMM)
                       || (ex_op_i == OP_SUBTRACT_WITH_BORROW_TO_MEM);
    wire [10:0] sres    = sub8(wreg_r, op_imm ? ex_imm_i : m,
                               op_brw & ~c_old);                  // RL7 RL9
    wire [7:0]  sdiff   = sres[7:0];
    wire        sz      = (sdiff == 8'h00);
    // Chained zero keeps earlier zero across a borrow chain
    wire        scz     = op_brw ? (sz & flags_r[FLG_CHAINED_ZERO]) : sz;
    wire [5:0]  sflags  = {scz, sres[10] ^ sdiff[7], sres[10], sz,
                           sres[9], sres[8]};                     // RL8

    // Bus request decode
    wire        bus_req = avs_read_i || avs_write_i;
    wire        bus_wr  = avs_write_i && !wait_r && avs_byteenable_i[0];
    wire        wr_wreg = bus_wr && (avs_address_i == REG_WREG);
    wire        wr_flag = bus_wr && (avs_address_i == REG_FLAGS);
    wire [31:0] rd_mux  = (avs_address_i == REG_WREG)  ? {24'h0, wreg_r} :
                          (avs_address_i == REG_FLAGS) ? {26'h0, flags_r} :
                          (avs_address_i == REG_SKIPS) ? {24'h0, skips_r} :
                                                         32'h0;

    // Per-operation result, destination, flags and skip condition
    logic skip_c;
    always_comb begin
        wreg_nxt      = wreg_r;
        flags_nxt     = flags_r;
        mem_we_nxt    = 1'b0;
        mem_wdata_nxt = mem_wdata_r;
        skip_c        = 1'b0;
        if (take) begin
            case (ex_op_i)
                OP_ROTATE_LEFT_THRU_CARRY: begin
                    mem_we_nxt       = 1'b1;                      // RL1
                    mem_wdata_nxt    = rot_lc;
                    flags_nxt[FLG_C] = m[7];
                end
                OP_ROTATE_LEFT_CARRY_TO_WREG: begin
                    wreg_nxt         = rot_lc;                    // RL2
                    flags_nxt[FLG_C] = m[7];
                end
                OP_ROTATE_RIGHT_PLAIN: begin
                    mem_we_nxt    = 1'b1;                         // RL3
                    mem_wdata_nxt = rot_r;
                end
                OP_ROTATE_RIGHT_TO_WREG: wreg_nxt = rot_r;        // RL4
                OP_ROTATE_RIGHT_THRU_CARRY: begin
                    mem_we_nxt       = 1'b1;                      // RL5
                    mem_wdata_nxt    = rot_rc;
                    flags_nxt[FLG_C] = m[0];
                end
                OP_ROTATE_RIGHT_CARRY_TO_WREG: begin
                    wreg_nxt         = rot_rc;                    // RL6
                    flags_nxt[FLG_C] = m[0];
                end
                OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_IMM,
                OP_SUB_M, OP_SUB_X: begin
                    wreg_nxt  = sdiff;                            // RL7 RL11
                    flags_nxt = sflags;
                end
                OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_MINUS_TO_MEM: begin
                    mem_we_nxt    = 1'b1;                         // RL10 RL12
                    mem_wdata_nxt = sdiff;
                    flags_nxt     = sflags;
                end
                OP_DEC_SKZ: begin
                    mem_we_nxt    = 1'b1;                         // RL13
                    mem_wdata_nxt = dec_v;
                    skip_c        = (dec_v == 8'h00);
                end
                OP_DEC_SKZ_W: begin
                    wreg_nxt = dec_v;                             // RL14
                    skip_c   = (dec_v == 8'h00);
                end
                OP_INC_SKZ: begin
                    mem_we_nxt    = 1'b1;                         // RL15
                    mem_wdata_nxt = inc_v;
                    skip_c        = (inc_v == 8'h00);
                end
                OP_INC_SKZ_W: begin
                    wreg_nxt = inc_v;                             // RL16
                    skip_c   = (inc_v == 8'h00);
                end
                OP_FILL: begin
                    mem_we_nxt    = 1'b1;                         // RL18
                    mem_wdata_nxt = BYTE_ONES;
                end
                OP_BIT_SET: begin
                    mem_we_nxt    = 1'b1;                         // RL19
                    mem_wdata_nxt = m | bitmask;
                end
                OP_SKNZ:      skip_c = (m != 8'h00);              // RL20
                OP_SKNZ_BIT:  skip_c = ((m & bitmask) != 8'h00);  // RL20
                OP_NIB_X: begin
                    mem_we_nxt    = 1'b1;                         // RL21
                    mem_wdata_nxt = nib_x;
                end
                OP_NIB_X_W:   wreg_nxt = nib_x;                   // RL22
                OP_SKZ:       skip_c = (m == 8'h00);              // RL23
                default: ;
            endcase
        end
        // A bus write in the same cycle overrides the operation result
        if (wr_wreg) begin
            wreg_nxt = avs_writedata_i[7:0];
        end
        if (wr_flag) begin
            flags_nxt = avs_writedata_i[5:0];
        end
    end

    // Sequencer: a taken skip parks one dummy cycle, else stay running
    always_comb begin
        case (state_r)
            ST_RUN:   state_nxt = (take && skip_c) ? ST_DUMMY : ST_RUN; // RL17
            ST_DUMMY: state_nxt = ST_RUN;                               // RL17
            default:  state_nxt = ST_RUN;
        endcase
    end

    // Execution state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r     <= ST_RUN;
            wreg_r      <= WREG_RST;
            flags_r     <= FLAGS_RST;
            mem_we_r    <= 1'b0;
            mem_wdata_r <= 8'h00;
            skip_r      <= 1'b0;
            busy_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            wreg_r      <= wreg_nxt;
            flags_r     <= flags_nxt;
            mem_we_r    <= mem_we_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            skip_r      <= take && skip_c;                        // RL17
            busy_r      <= (state_nxt == ST_DUMMY);
        end
    end

    // Skip counter, a status view for software; wraps at 255
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            skips_r <= 8'h00;
        end else if (take && skip_c) begin
            skips_r <= skips_r + 8'h01;
        end
    end

    // Bus slave: one wait cycle on every access, answer on the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r  <= !(bus_req && wait_r);
            rdata_r <= (avs_read_i && wait_r) ? rd_mux : rdata_r;
        end
    end

    assign ex_busy_o         = busy_r;
    assign skip_o            = skip_r;
    assign mem_we_o          = mem_we_r;
    assign mem_wdata_o       = mem_wdata_r;
    assign wreg_o            = wreg_r;
    assign flags_o           = flags_r;
    assign avs_readdata_o    = rdata_r;
    assign avs_waitrequest_o = wait_r;

    // Checks
    wire quiet = !bus_wr;

    property p_rlc_mem;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_ROTATE_LEFT_THRU_CARRY && quiet) |=>
            mem_we_o && mem_wdata_o == {$past(m[6:0]), $past(c_old)}
            && flags_o[FLG_C] == $past(m[7]);
    endproperty
    a_rlc_mem: assert property (p_rlc_mem) // RL1
        else $error("rotate left through carry result wrong");

    property p_rr_noflag;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_ROTATE_RIGHT_PLAIN && quiet) |=>
            flags_o == $past(flags_r) && mem_wdata_o == $past(rot_r);
    endproperty
    a_rr_noflag: assert property (p_rr_noflag) // RL3
        else $error("plain right rotate touched flags or data");

    property p_rotate_right_carry_to_wreg;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_ROTATE_RIGHT_CARRY_TO_WREG && quiet) |=>
            !mem_we_o && wreg_o == {$past(c_old), $past(m[7:1])}
            && flags_o[FLG_C] == $past(m[0]);
    endproperty
    a_rotate_right_carry_to_wreg: assert property (p_rotate_right_carry_to_wreg) // RL6
        else $error("right carry rotate to working register wrong");

    property p_sub_carry;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_SUB_M && quiet) |=>
            flags_o[FLG_C] == ($past(wreg_r) >= $past(m))
            && wreg_o == 8'($past(wreg_r) - $past(m));
    endproperty
    a_sub_carry: assert property (p_sub_carry) // RL8
        else $error("subtract carry or difference wrong");

    property p_sbc_imm;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_SUBTRACT_WITH_BORROW_IMM && quiet) |=>
            wreg_o == 8'($past(wreg_r) - $past(ex_imm_i)
                         - {7'h0, ~$past(c_old)});
    endproperty
    a_sbc_imm: assert property (p_sbc_imm) // RL9
        else $error("immediate subtract with borrow wrong");

    sequence s_skip_taken;
        take && skip_c;
    endsequence
    sequence s_dummy_then_run;
        (skip_o && ex_busy_o) ##1 (!skip_o && !ex_busy_o);
    endsequence
    property p_skip_two;
        @(posedge clk_i) disable iff (rst_i)
        s_skip_taken |=> s_dummy_then_run;
    endproperty
    a_skip_two: assert property (p_skip_two) // RL17
        else $error("taken skip did not last two cycles");

    property p_noskip_one;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_SKNZ && m == 8'h00) |=>
            !skip_o && !ex_busy_o;
    endproperty
    a_noskip_one: assert property (p_noskip_one) // RL24
        else $error("untaken skip stalled the core");

    property p_dec_skip;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_DEC_SKZ && m == 8'h01) |=>
            skip_o && mem_we_o && mem_wdata_o == 8'h00;
    endproperty
    a_dec_skip: assert property (p_dec_skip) // RL13
        else $error("decrement to zero did not skip");

    property p_bit_set;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_BIT_SET) |=>
            mem_we_o && mem_wdata_o == ($past(m) | $past(bitmask))
            && $countones(mem_wdata_o ^ $past(m)) <= 1;
    endproperty
    a_bit_set: assert property (p_bit_set) // RL19
        else $error("bit set changed other bits");

    property p_nibble_exchange_to_wreg;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_NIB_X_W && quiet) |=>
            !mem_we_o && wreg_o == {$past(m[3:0]), $past(m[7:4])};
    endproperty
    a_nibble_exchange_to_wreg: assert property (p_nibble_exchange_to_wreg) // RL22
        else $error("nibble swap to working register wrong");

    property p_fill;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_FILL && quiet) |=>
            mem_we_o && mem_wdata_o == BYTE_ONES
            && flags_o == $past(flags_r);
    endproperty
    a_fill: assert property (p_fill) // RL18
        else $error("byte fill result or flags wrong");

    property p_nib_mem;
        @(posedge clk_i) disable iff (rst_i)
        (take && ex_op_i == OP_NIB_X && quiet) |=>
            mem_we_o && mem_wdata_o == {$past(m[3:0]), $past(m[7:4])}
            && flags_o == $past(flags_r) && wreg_o == $past(wreg_r);
    endproperty
    a_nib_mem: assert property (p_nib_mem) // RL21
        else $error("nibble swap in memory wrong");

endmodule

`default_nettype wire

// ===== bench/rss_decoder_model.sv
// Behavioural model of the core's fetch and decode side.
// Assumes one clock shared with the execution slice; ops are issued by
// calling issue() from the bench, which blocks until results are visible.
`timescale 1ns/10ps
`default_nettype none
module rss_decoder_model (
    // Clock and back-pressure
    input  wire logic       clk_i,
    input  wire logic       ex_busy_i,
    // Operation towards the execution slice
    output logic            ex_valid_o,
    output logic [4:0]      ex_op_o,
    output logic [7:0]      ex_mem_o,
    output logic [7:0]      ex_imm_o,
    output logic [2:0]      ex_bit_o
);
    // Idle state at time zero: nothing presented
    initial begin
        ex_valid_o = 1'b0;
        ex_op_o    = 5'h00;
        ex_mem_o   = 8'h00;
        ex_imm_o   = 8'h00;
        ex_bit_o   = 3'h0;
    end

    // Present one op, hold it through the taking edge, then release
    task automatic issue(input logic [4:0] op, input logic [7:0] m,
                         input logic [7:0] x, input logic [2:0] b);
        @(negedge clk_i);
        while (ex_busy_i !== 1'b0) @(negedge clk_i);
        @(posedge clk_i);
        ex_valid_o <= 1'b1;
        ex_op_o    <= op;
        ex_mem_o   <= m;
        ex_imm_o   <= x;
        ex_bit_o   <= b;
        @(posedge clk_i);
        // Released operand lines show the inverse, op is held, so a stale operand cannot pass
        ex_valid_o <= 1'b0;
        ex_mem_o   <= ~m;
        ex_imm_o   <= ~x;
        ex_bit_o   <= ~b;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== bench/mcu_rotate_subtract_skip_ops_bench.sv
// Self-checking bench for the rotate / subtract / skip execution slice.
// Assumes rss_pkg and the decoder model; registers are preset over Avalon.
`timescale 1ns/10ps
`default_nettype none
module mcu_rotate_subtract_skip_ops_bench import rss_pkg::*; ;
    // Clock, reset and operation lines
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ex_valid_i, ex_busy_o, skip_o, mem_we_o;
    logic [4:0]  ex_op_i;
    logic [7:0]  ex_mem_i, ex_imm_i, mem_wdata_o, wreg_o;
    logic [2:0]  ex_bit_i;
    logic [5:0]  flags_o;
    // Register bus
    logic [1:0]  avs_address_i    = 2'h0;
    logic        avs_read_i       = 1'b0;
    logic        avs_write_i      = 1'b0;
    logic [31:0] avs_writedata_i  = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o, rd;
    logic        avs_waitrequest_o;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          skips = 0;

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    rss_exec dut (
        .clk_i(clk_i), .rst_i(rst_i), .ex_valid_i(ex_valid_i),
        .ex_op_i(ex_op_i), .ex_mem_i(ex_mem_i), .ex_imm_i(ex_imm_i),
        .ex_bit_i(ex_bit_i), .ex_busy_o(ex_busy_o), .skip_o(skip_o),
        .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .wreg_o(wreg_o),
        .flags_o(flags_o), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o)
    );

    rss_decoder_model dec (
        .clk_i(clk_i), .ex_busy_i(ex_busy_o), .ex_valid_o(ex_valid_i),
        .ex_op_o(ex_op_i), .ex_mem_o(ex_mem_i), .ex_imm_o(ex_imm_i),
        .ex_bit_o(ex_bit_i)
    );

    // Count every compare, report a mismatch at once
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest samples low
    task automatic bus(input logic wr, input logic [1:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_i);
        avs_address_i    <= a;
        avs_writedata_i  <= {24'h0, d};
        avs_byteenable_i <= be;
        avs_write_i      <= wr;
        avs_read_i       <= !wr;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    // Preset wreg and flags, issue one op, check results and the dummy slot
    task automatic run(input logic [4:0] op, input logic [7:0] w, f, m, x,
                       input logic we, input logic [7:0] res, fm, fe,
                       input logic sk);
        bus(1'b1, REG_WREG, w, 4'hF);
        bus(1'b1, REG_FLAGS, f, 4'hF);
        dec.issue(op, m, x, x[2:0]);
        chk({7'h0, mem_we_o}, {7'h0, we});
        if (we) begin
            chk(mem_wdata_o, res);
            chk(wreg_o, w);
        end else begin
            chk(wreg_o, res);
        end
        chk({2'h0, flags_o & fm[5:0]}, fe);
        chk({6'h0, skip_o, ex_busy_o}, {6'h0, sk, sk});
        @(negedge clk_i);
        chk({5'h0, ex_busy_o, skip_o, mem_we_o}, 8'h00);
        skips = skips + int'(sk);
    endtask

    // Summary line, verdict and end of run
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, REG_WREG, 8'h00, 4'hF);
        chk(rd[7:0], WREG_RST);
        bus(1'b0, REG_FLAGS, 8'h00, 4'hF);
        chk(rd[7:0], {2'h0, FLAGS_RST});
        run(OP_ROTATE_LEFT_THRU_CARRY, 8'h00, 8'h01, 8'h05, 8'h00,
            1'b1, 8'h0B, 8'h3F, 8'h00, 1'b0);
        run(OP_ROTATE_LEFT_CARRY_TO_WREG, 8'h33, 8'h00, 8'h80, 8'h00,
            1'b0, 8'h00, 8'h3F, 8'h01, 1'b0);
        run(OP_ROTATE_RIGHT_PLAIN, 8'h5A, 8'h15, 8'h01, 8'h00,
            1'b1, 8'h80, 8'h3F, 8'h15, 1'b0);
        run(OP_ROTATE_RIGHT_TO_WREG, 8'h00, 8'h2A, 8'h02, 8'h00,
            1'b0, 8'h01, 8'h3F, 8'h2A, 1'b0);
        run(OP_ROTATE_RIGHT_THRU_CARRY, 8'h00, 8'h01, 8'h02, 8'h00,
            1'b1, 8'h81, 8'h3F, 8'h00, 1'b0);
        run(OP_ROTATE_RIGHT_CARRY_TO_WREG, 8'h00, 8'h00, 8'h01, 8'h00,
            1'b0, 8'h00, 8'h3F, 8'h01, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW, 8'h10, 8'h00, 8'h05, 8'h00,
            1'b0, 8'h0A, 8'h3F, 8'h01, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW, 8'h05, 8'h21, 8'h05, 8'h00,
            1'b0, 8'h00, 8'h3F, 8'h27, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW_IMM, 8'h00, 8'h01, 8'h00, 8'h01,
            1'b0, 8'hFF, 8'h3F, 8'h10, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW_IMM, 8'h05, 8'h01, 8'h00, 8'h05,
            1'b0, 8'h00, 8'h3F, 8'h07, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW_TO_MEM, 8'h80, 8'h00, 8'h01, 8'h00,
            1'b1, 8'h7E, 8'h3F, 8'h19, 1'b0);
        run(OP_SUB_M, 8'h05, 8'h01, 8'h10, 8'h00,
            1'b0, 8'hF5, 8'h3F, 8'h12, 1'b0);
        run(OP_SUB_X, 8'h42, 8'h00, 8'h00, 8'h42,
            1'b0, 8'h00, 8'h3F, 8'h27, 1'b0);
        run(OP_MINUS_TO_MEM, 8'h03, 8'h00, 8'h03, 8'h00,
            1'b1, 8'h00, 8'h3F, 8'h27, 1'b0);
        run(OP_DEC_SKZ, 8'h77, 8'h15, 8'h01, 8'h00,
            1'b1, 8'h00, 8'h3F, 8'h15, 1'b1);
        run(OP_DEC_SKZ, 8'h77, 8'h15, 8'h00, 8'h00,
            1'b1, 8'hFF, 8'h3F, 8'h15, 1'b0);
        run(OP_DEC_SKZ_W, 8'h77, 8'h15, 8'h01, 8'h00,
            1'b0, 8'h00, 8'h3F, 8'h15, 1'b1);
        run(OP_INC_SKZ, 8'h77, 8'h15, 8'hFF, 8'h00,
            1'b1, 8'h00, 8'h3F, 8'h15, 1'b1);
        run(OP_INC_SKZ, 8'h77, 8'h15, 8'h7F, 8'h00,
            1'b1, 8'h80, 8'h3F, 8'h15, 1'b0);
        run(OP_INC_SKZ_W, 8'h77, 8'h15, 8'hFF, 8'h00,
            1'b0, 8'h00, 8'h3F, 8'h15, 1'b1);
        run(OP_FILL, 8'h77, 8'h15, 8'h12, 8'h00,
            1'b1, BYTE_ONES, 8'h3F, 8'h15, 1'b0);
        run(OP_BIT_SET, 8'h77, 8'h15, 8'h41, 8'h07,
            1'b1, 8'hC1, 8'h3F, 8'h15, 1'b0);
        run(OP_SKNZ, 8'h77, 8'h15, 8'h01, 8'h00,
            1'b0, 8'h77, 8'h3F, 8'h15, 1'b1);
        run(OP_SKNZ, 8'h77, 8'h15, 8'h00, 8'h00,
            1'b0, 8'h77, 8'h3F, 8'h15, 1'b0);
        run(OP_SKNZ_BIT, 8'h77, 8'h15, 8'hFB, 8'h02,
            1'b0, 8'h77, 8'h3F, 8'h15, 1'b0);
        run(OP_SKNZ_BIT, 8'h77, 8'h15, 8'h04, 8'h02,
            1'b0, 8'h77, 8'h3F, 8'h15, 1'b1);
        run(OP_NIB_X, 8'h77, 8'h15, 8'hA5, 8'h00,
            1'b1, 8'h5A, 8'h3F, 8'h15, 1'b0);
        run(OP_NIB_X_W, 8'h77, 8'h15, 8'h3C, 8'h00,
            1'b0, 8'hC3, 8'h3F, 8'h15, 1'b0);
        run(OP_SKZ, 8'h77, 8'h15, 8'h00, 8'h00,
            1'b0, 8'h77, 8'h3F, 8'h15, 1'b1);
        run(OP_SKZ, 8'h77, 8'h15, 8'h10, 8'h00,
            1'b0, 8'h77, 8'h3F, 8'h15, 1'b0);
        // Refused writes: masked lane, read-only counter, unmapped index
        bus(1'b1, REG_WREG, 8'h11, 4'hF);
        bus(1'b1, REG_WREG, 8'h22, 4'hE);
        bus(1'b0, REG_WREG, 8'h00, 4'hF);
        chk(rd[7:0], 8'h11);
        bus(1'b1, REG_SKIPS, 8'h55, 4'hF);
        bus(1'b0, REG_SKIPS, 8'h00, 4'hF);
        chk(rd[7:0], skips[7:0]);
        chk(rd[31:24], 8'h00);
        bus(1'b1, 2'h3, 8'h66, 4'hF);
        bus(1'b0, 2'h3, 8'h00, 4'hF);
        chk(rd[7:0], 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
